// >>> rtl/lae_defs.svh
// Purpose: Constants of the logical AND execute unit
// Assumes: Byte addresses on a 32-bit AHB-Lite bus
// Notes:   Offsets, opcode fields, flag positions, reset values
//
// Operation
// (RULE_01) Literal form: top byte fixed, width bit, ten-bit literal, register in low nibble.
// (RULE_02) Literal form takes the ten k bits as the literal operand.
// (RULE_03) Literal form d bits pick the work register, operand and result.
// (RULE_04) Width bit 0 gives word operation, 1 gives byte operation.
// (RULE_05) Short literal form: base, width, target mode, target, two ones, five-bit literal.
// (RULE_06) Register form: base, width, target mode and register, source mode and register.
// (RULE_07) Only negative and zero status flags change; other status bits keep.
// (RULE_08) Byte variant works byte-wide; word is the default.
// (RULE_09) Register form p bits give the source addressing mode.
// (RULE_10) Register form s bits give the source register number.
// (RULE_11) Result is bitwise AND; byte writes low byte; N top bit, Z zero.
// (RULE_12) Each form is one instruction word, one instruction pass.
`ifndef LAE_DEFS_SVH
`define LAE_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LAE_OFF_CODE   3'h0
`define LAE_OFF_FLAGS  3'h1
`define LAE_OFF_SEL    3'h2
`define LAE_OFF_DATA   3'h3
`define LAE_OFF_STAT   3'h4
`define LAE_OFF_NONE   3'h7

// ----------------------------------------------------------------
// Opcode fields and addressing modes
// ----------------------------------------------------------------
`define LAE_OP_LIT     8'hb2
`define LAE_OP_BASE    5'h0c
`define LAE_SHORT_TAG  2'h3
`define LAE_M_DIRECT   3'h0
`define LAE_M_POSTDEC  3'h2
`define LAE_M_POSTINC  3'h3
`define LAE_M_PREDEC   3'h4
`define LAE_M_PREINC   3'h5

// ----------------------------------------------------------------
// Status bits and reset values
// ----------------------------------------------------------------
`define LAE_SR_N       3
`define LAE_SR_Z       1
`define LAE_SR_NZ      16'h000a
`define LAE_SR_RST     16'h0000
`define LAE_STEP_B     16'h0001
`define LAE_STEP_W     16'h0002

`endif

// >>> rtl/lae_pkg.sv
// Purpose: Types of the logical AND execute unit
// Assumes: Nothing beyond the constants header
// Notes:   Whole module state is one packed struct
package lae_pkg;

	// ------------------------------------------------------------
	// Sequencer states, Gray along IDLE-DEC-RD-EXEC-WRB; DEC to EXEC and WRB to IDLE flip two bits
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		LAE_IDLE = 3'h0,
		LAE_DEC  = 3'h1,
		LAE_RD   = 3'h3,
		LAE_EXEC = 3'h2,
		LAE_WRB  = 3'h6
	} lae_state_type;

	// ------------------------------------------------------------
	// Complete state of the unit
	// ------------------------------------------------------------
	typedef struct packed
	{
		lae_state_type     state;
		logic [23:0]       code;
		logic [15:0][15:0] wr;
		logic [15:0]       sr;
		logic [3:0]        sel;
		logic              illegal;
		logic [31:0]       rdata;
		logic [15:0]       memAddr;
		logic [15:0]       memWdata;
		logic              memByte;
		logic              apWr;
		logic [2:0]        apIdx;
	} lae_state_s_type;

endpackage : lae_pkg

// >>> rtl/lae_unit.sv
// Purpose: Decodes and executes the AND family on 16 work registers
// Assumes: Data memory answers a read on the cycle after memRdEn
// Notes:   AHB-Lite slave, zero wait states, always OKAY
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
`include "lae_defs.svh"

module lae_unit
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Data memory port
	output logic             memRdEn,
	output logic             memWrEn,
	output logic             memByte,
	output logic [15:0]      memAddr,
	output logic [15:0]      memWdata,
	input  wire logic [15:0] memRdata
);

	lae_pkg::lae_state_s_type st_r;
	lae_pkg::lae_state_s_type st_nxt;

	logic        isLit;
	logic        isBase;
	logic        isShort;
	logic        isByte;
	logic        legal;
	logic        srcInd;
	logic        writeReg;
	logic        apValid;
	logic [9:0]  litLong;
	logic [4:0]  litShort;
	logic [3:0]  baseIdx;
	logic [3:0]  tgtIdx;
	logic [3:0]  srcIdx;
	logic [2:0]  tgtMode;
	logic [2:0]  srcMode;
	logic [15:0] step;
	logic [15:0] opA;
	logic [15:0] opB;
	logic [15:0] andRaw;
	logic [15:0] merged;
	logic [15:0] tgtOld;
	logic [15:0] srcPtr;
	logic [15:0] srKeep;
	logic        startPulse;

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	function automatic logic [2:0] regIndex(input logic [31:0] a);
		if (a[31:5] != 27'h0 || a[1:0] != 2'h0)
			regIndex = `LAE_OFF_NONE;
		else if (a[4:2] <= `LAE_OFF_STAT)
			regIndex = a[4:2];
		else
			regIndex = `LAE_OFF_NONE;
	endfunction : regIndex

	function automatic logic [15:0] effAddr(input logic [15:0] p, input logic [2:0] m, input logic [15:0] s);
		if (m == `LAE_M_PREDEC)
			effAddr = p - s;
		else if (m == `LAE_M_PREINC)
			effAddr = p + s;
		else
			effAddr = p;
	endfunction : effAddr

	function automatic logic [15:0] ptrNext(input logic [15:0] p, input logic [2:0] m, input logic [15:0] s);
		if (m == `LAE_M_POSTDEC || m == `LAE_M_PREDEC)
			ptrNext = p - s;
		else if (m == `LAE_M_POSTINC || m == `LAE_M_PREINC)
			ptrNext = p + s;
		else
			ptrNext = p;
	endfunction : ptrNext

	// ------------------------------------------------------------
	// Opcode field decode
	// ------------------------------------------------------------
	always_comb
	begin
		isLit    = st_r.code[23:16] == `LAE_OP_LIT && !st_r.code[15]; // RULE_01
		isBase   = st_r.code[23:19] == `LAE_OP_BASE; // RULE_05
		isShort  = isBase && st_r.code[6:5] == `LAE_SHORT_TAG; // RULE_05
		isByte   = st_r.code[14]; // RULE_04
		litLong  = st_r.code[13:4]; // RULE_02
		litShort = st_r.code[4:0];
		baseIdx  = st_r.code[18:15];
		tgtMode  = isLit ? `LAE_M_DIRECT : st_r.code[13:11];
		tgtIdx   = isLit ? st_r.code[3:0] : st_r.code[10:7]; // RULE_03
		srcMode  = st_r.code[6:4]; // RULE_09
		srcIdx   = st_r.code[3:0]; // RULE_10
		step     = isByte ? `LAE_STEP_B : `LAE_STEP_W; // RULE_08
		srcInd   = isBase && !isShort && srcMode != `LAE_M_DIRECT;
		legal    = isLit || (isBase && tgtMode <= `LAE_M_PREINC && (isShort || srcMode <= `LAE_M_PREINC));
		writeReg = tgtMode == `LAE_M_DIRECT;
		srcPtr   = st_r.wr[srcIdx];
		tgtOld   = st_r.wr[tgtIdx];
		srKeep   = st_r.sr & ~`LAE_SR_NZ;
	end

	// Operands, result and byte merge
	always_comb
	begin
		opA = isLit ? st_r.wr[tgtIdx] : st_r.wr[baseIdx]; // RULE_03
		if (isLit)
			opB = {6'h00, litLong}; // RULE_02
		else if (isShort)
			opB = {11'h000, litShort}; // RULE_05
		else if (srcMode == `LAE_M_DIRECT)
			opB = st_r.wr[srcIdx]; // RULE_10
		else
			opB = memRdata; // RULE_06
		andRaw = opA & opB; // RULE_11
		merged = isByte ? {tgtOld[15:8], andRaw[7:0]} : andRaw; // RULE_11
	end

	// ------------------------------------------------------------
	// Next-state logic: bus writes first, sequencer after them so it wins, address capture last
	// ------------------------------------------------------------
	always_comb
	begin
		st_nxt     = st_r;
		apValid    = hsel && htrans[1] && hready;
		startPulse = st_r.apWr && st_r.apIdx == `LAE_OFF_CODE && st_r.state == lae_pkg::LAE_IDLE;
		// Data phase of a write
		if (st_r.apWr)
		begin
			if (st_r.apIdx == `LAE_OFF_CODE && st_r.state == lae_pkg::LAE_IDLE)
			begin
				st_nxt.code  = hwdata[23:0];
				st_nxt.state = lae_pkg::LAE_DEC;
			end
			else if (st_r.apIdx == `LAE_OFF_FLAGS)
				st_nxt.sr = hwdata[15:0];
			else if (st_r.apIdx == `LAE_OFF_SEL)
				st_nxt.sel = hwdata[3:0];
			else if (st_r.apIdx == `LAE_OFF_DATA && st_r.state == lae_pkg::LAE_IDLE)
				st_nxt.wr[st_r.sel] = hwdata[15:0];
			else if (st_r.apIdx == `LAE_OFF_STAT && hwdata[1])
				st_nxt.illegal = 1'b0;
		end
		// Sequencer
		case (st_r.state)
			lae_pkg::LAE_DEC:
			begin
				if (!legal)
				begin
					st_nxt.illegal = 1'b1; // RULE_01
					st_nxt.state   = lae_pkg::LAE_IDLE;
				end
				else if (srcInd)
				begin
					st_nxt.memAddr     = effAddr(srcPtr, srcMode, step); // RULE_09
					st_nxt.memByte     = isByte;
					st_nxt.wr[srcIdx]  = ptrNext(srcPtr, srcMode, step); // RULE_09
					st_nxt.state       = lae_pkg::LAE_RD;
				end
				else
					st_nxt.state = lae_pkg::LAE_EXEC;
			end
			lae_pkg::LAE_RD:
				st_nxt.state = lae_pkg::LAE_EXEC;
			lae_pkg::LAE_EXEC:
			begin
				st_nxt.sr[`LAE_SR_N] = isByte ? andRaw[7] : andRaw[15]; // RULE_07
				st_nxt.sr[`LAE_SR_Z] = isByte ? andRaw[7:0] == 8'h00 : andRaw == 16'h0000; // RULE_07
				if (writeReg)
				begin
					st_nxt.wr[tgtIdx] = merged; // RULE_11
					st_nxt.state      = lae_pkg::LAE_IDLE; // RULE_12
				end
				else
				begin
					st_nxt.memAddr    = effAddr(tgtOld, tgtMode, step); // RULE_06
					st_nxt.memWdata   = andRaw;
					st_nxt.memByte    = isByte; // RULE_04
					st_nxt.wr[tgtIdx] = ptrNext(tgtOld, tgtMode, step);
					st_nxt.state      = lae_pkg::LAE_WRB;
				end
			end
			lae_pkg::LAE_WRB:
				st_nxt.state = lae_pkg::LAE_IDLE; // RULE_12
			default:
				st_nxt.state = st_nxt.state;
		endcase
		// Address phase capture and read data
		st_nxt.apWr  = apValid && hwrite;
		st_nxt.apIdx = regIndex(haddr);
		if (apValid && !hwrite)
		begin
			if (regIndex(haddr) == `LAE_OFF_CODE)
				st_nxt.rdata = {8'h00, st_nxt.code};
			else if (regIndex(haddr) == `LAE_OFF_FLAGS)
				st_nxt.rdata = {16'h0000, st_nxt.sr};
			else if (regIndex(haddr) == `LAE_OFF_SEL)
				st_nxt.rdata = {28'h0000000, st_nxt.sel};
			else if (regIndex(haddr) == `LAE_OFF_DATA)
				st_nxt.rdata = {16'h0000, st_nxt.wr[st_nxt.sel]};
			else if (regIndex(haddr) == `LAE_OFF_STAT)
				st_nxt.rdata = {30'h00000000, st_nxt.illegal, st_nxt.state != lae_pkg::LAE_IDLE};
			else
				st_nxt.rdata = 32'h00000000;
		end
	end

	// State register
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			st_r       <= '0;
			st_r.state <= lae_pkg::LAE_IDLE;
			st_r.sr    <= `LAE_SR_RST;
		end
		else
			st_r <= st_nxt;
	end

	// Outputs
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = st_r.rdata;
	assign memRdEn   = st_r.state == lae_pkg::LAE_RD;
	assign memWrEn   = st_r.state == lae_pkg::LAE_WRB;
	assign memByte   = st_r.memByte;
	assign memAddr   = st_r.memAddr;
	assign memWdata  = st_r.memWdata;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_LIT_WORD: assert property (@(posedge mclk) disable iff (rst) // RULE_02
		(st_r.state == lae_pkg::LAE_EXEC && isLit && !isByte)
		|=> st_r.wr[$past(tgtIdx)] == ($past(opA) & {6'h00, $past(litLong)}))
		else $error("literal form word result wrong");
	AST_BYTE_HIGH: assert property (@(posedge mclk) disable iff (rst) // RULE_11
		(st_r.state == lae_pkg::LAE_EXEC && writeReg && isByte)
		|=> st_r.wr[$past(tgtIdx)][15:8] == $past(tgtOld[15:8]))
		else $error("byte operation touched the high byte");
	AST_SR_KEEP: assert property (@(posedge mclk) disable iff (rst) // RULE_07
		(st_r.state == lae_pkg::LAE_EXEC && !(st_r.apWr && st_r.apIdx == `LAE_OFF_FLAGS))
		|=> (st_r.sr & ~`LAE_SR_NZ) == $past(srKeep))
		else $error("status bits other than N and Z changed");
	AST_ZERO_BYTE: assert property (@(posedge mclk) disable iff (rst) // RULE_11
		(st_r.state == lae_pkg::LAE_EXEC && isByte)
		|=> st_r.sr[`LAE_SR_Z] == ($past(opA[7:0] & opB[7:0]) == 8'h00))
		else $error("zero flag wrong in byte mode");
	AST_NEG_WORD: assert property (@(posedge mclk) disable iff (rst) // RULE_04
		(st_r.state == lae_pkg::LAE_EXEC && !isByte)
		|=> st_r.sr[`LAE_SR_N] == ($past(opA[15]) && $past(opB[15])))
		else $error("negative flag wrong in word mode");
	AST_ONE_PASS: assert property (@(posedge mclk) disable iff (rst) // RULE_12
		startPulse |-> ##[2:5] (st_r.state == lae_pkg::LAE_IDLE))
		else $error("instruction did not complete");
	AST_SRC_POSTINC: assert property (@(posedge mclk) disable iff (rst) // RULE_09
		(st_r.state == lae_pkg::LAE_DEC && legal && srcInd && srcMode == `LAE_M_POSTINC)
		|=> memRdEn && memAddr == $past(srcPtr) && st_r.wr[$past(srcIdx)] == $past(srcPtr) + $past(step))
		else $error("source post-increment wrong");
	AST_SHORT_WORD: assert property (@(posedge mclk) disable iff (rst) // RULE_05
		(st_r.state == lae_pkg::LAE_EXEC && isShort && writeReg && !isByte)
		|=> st_r.wr[$past(tgtIdx)] == ($past(opA) & {11'h000, $past(litShort)}))
		else $error("short literal result wrong");
	AST_MEM_WRITE: assert property (@(posedge mclk) disable iff (rst) // RULE_06
		(st_r.state == lae_pkg::LAE_EXEC && !writeReg)
		|=> memWrEn && memWdata == $past(andRaw) ##1 !memWrEn)
		else $error("memory target write wrong");
	AST_ILLEGAL: assert property (@(posedge mclk) disable iff (rst) // RULE_01
		(st_r.state == lae_pkg::LAE_DEC && !legal)
		|=> st_r.illegal && st_r.state == lae_pkg::LAE_IDLE)
		else $error("unknown opcode not flagged");

endmodule : lae_unit

// >>> bench/lae_mem_model.sv
// Purpose: Data memory on the far side of the AND unit
// Assumes: Read data is due in the cycle after memRdEn
// Notes:   Each byte is preset from its own address
`timescale 1ns/1ns
module lae_mem_model
(
	// Clock
	input  wire logic        mclk,
	// Memory port
	input  wire logic        memRdEn,
	input  wire logic        memWrEn,
	input  wire logic        memByte,
	input  wire logic [15:0] memAddr,
	input  wire logic [15:0] memWdata,
	output logic      [15:0] memRdata
);
	logic [7:0]  mem [0:65535];
	logic [15:0] rdReg = 16'h0000;

	// Single driver of the read port
	assign memRdata = rdReg;

	// Preset pattern, known to the bench
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = i[7:0] ^ i[15:8] ^ 8'h3c;
	end

	// Answer one cycle after the strobe, toggling junk otherwise
	always @(posedge mclk)
	begin
		if (memRdEn)
			rdReg <= memByte ? {8'h00, mem[memAddr]} : {mem[memAddr + 16'h0001], mem[memAddr]};
		else
			rdReg <= ~rdReg;
		if (memWrEn)
		begin
			mem[memAddr] <= memWdata[7:0];
			if (!memByte)
				mem[memAddr + 16'h0001] <= memWdata[15:8];
		end
	end
endmodule : lae_mem_model

// >>> bench/lae_unit_bench.sv
// Purpose: Self-checking bench of the AND unit
// Assumes: Zero-wait AHB-Lite slave, memory model on the far side
// Notes:   Registers reached by byte address, four per index
`timescale 1ns/1ns
`include "lae_defs.svh"
module lae_unit_bench;
	localparam logic [31:0] ACODE = {27'h0, `LAE_OFF_CODE, 2'h0};
	localparam logic [31:0] AFLAGS = {27'h0, `LAE_OFF_FLAGS, 2'h0};
	localparam logic [31:0] ASEL = {27'h0, `LAE_OFF_SEL, 2'h0};
	localparam logic [31:0] ADATA = {27'h0, `LAE_OFF_DATA, 2'h0};
	localparam logic [31:0] ASTAT = {27'h0, `LAE_OFF_STAT, 2'h0};
	localparam logic [31:0] ANONE = {27'h0, `LAE_OFF_NONE, 2'h0};
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic        hready, hresp, memRdEn, memWrEn, memByte;
	logic [31:0] hrdata;
	logic [15:0] memAddr, memWdata, memRdata;
	int          err_total = 0;
	int          n_checks = 0;
	int          cyc = 0;

	// ------------------------------------------------------------
	// Clock, watchdog, design and memory
	// ------------------------------------------------------------
	always #5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_total++;
			wrap_up();
		end
	end
	lae_unit u_dut (.mclk(mclk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
		.hresp(hresp), .hrdata(hrdata), .memRdEn(memRdEn), .memWrEn(memWrEn), .memByte(memByte),
		.memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata));
	lae_mem_model u_mem (.mclk(mclk), .memRdEn(memRdEn), .memWrEn(memWrEn), .memByte(memByte),
		.memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic wrap_up();
		$display("Checks %0d, errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want)
		begin
			err_total++;
			$display("Error at %0t: seen %h want %h", $time, seen, want);
		end
	endtask : check

	// One single transfer, entered just after a rising edge
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge mclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		q = hrdata;
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] want);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		check(q, want);
	endtask : rd

	task automatic setw(input logic [3:0] n, input logic [15:0] v);
		wr(ASEL, {28'h0, n});
		wr(ADATA, {16'h0, v});
	endtask : setw

	task automatic getw(input logic [3:0] n, input logic [15:0] v);
		wr(ASEL, {28'h0, n});
		rd(ADATA, {16'h0, v});
	endtask : getw

	// Start an opcode, busy first unless refused at decode, then idle within two more polls
	task automatic run(input logic [23:0] code, input logic busyWant = 1'b1);
		logic [31:0] q;
		wr(ACODE, {8'h00, code});
		bus(ASTAT, 1'b0, 32'h0, q);
		check(q[0], busyWant);
		check({31'h0, hresp}, 32'h0);
		for (int n = 0; n < 2 && q[0] === 1'b1; n++)
			bus(ASTAT, 1'b0, 32'h0, q);
		check(q[0], 1'b0);
	endtask : run

	function automatic logic [23:0] lit(logic b, logic [9:0] k, logic [3:0] d);
		return {`LAE_OP_LIT, 1'b0, b, k, d};
	endfunction : lit

	function automatic logic [23:0] frm(logic [3:0] w, logic b, logic [2:0] q, logic [3:0] d, logic [6:0] lo);
		return {`LAE_OP_BASE, w, b, q, d, lo};
	endfunction : frm

	// Word of the preset memory pattern
	function automatic logic [15:0] pw(logic [15:0] a);
		logic [15:0] b;
		b = a + 16'h0001;
		return {b[7:0] ^ b[15:8] ^ 8'h3c, a[7:0] ^ a[15:8] ^ 8'h3c};
	endfunction : pw

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_literal();
		rd(ASTAT, 32'h0);
		wr(ANONE, 32'hffffffff);
		rd(ANONE, 32'h0);
		setw(1, 16'h12d0);
		wr(AFLAGS, 32'h0000fff5);
		run(lit(1'b0, 10'h333, 4'h1));
		getw(1, 16'h0210);
		rd(AFLAGS, 32'h0000fff5);
		setw(7, 16'h12c0);
		run(lit(1'b1, 10'h083, 4'h7));
		getw(7, 16'h1280);
		rd(AFLAGS, 32'h0000fffd);
		setw(3, 16'hab0f);
		run(lit(1'b1, 10'h0f0, 4'h3));
		getw(3, 16'hab00);
		rd(AFLAGS, 32'h0000fff7);
	endtask : t_literal

	task automatic t_short();
		setw(0, 16'h23a5);
		run(frm(4'h0, 1'b0, `LAE_M_DIRECT, 4'h1, {`LAE_SHORT_TAG, 5'h1f}));
		getw(1, 16'h0005);
		setw(1, 16'h2211);
		run(frm(4'h0, 1'b1, `LAE_M_POSTINC, 4'h1, {`LAE_SHORT_TAG, 5'h03}));
		check(u_mem.mem[16'h2211], 8'h01);
		check(u_mem.mem[16'h2210], 8'h0e);
		getw(1, 16'h2212);
	endtask : t_short

	// Source modes direct and indirect, word step
	task automatic t_reg();
		logic [15:0] ea, pa;
		setw(4, 16'hffff);
		for (int p = 0; p < 6; p++)
		begin
			ea = (p == 4) ? 16'h0ffe : (p == 5) ? 16'h1002 : 16'h1000;
			pa = (p == 2 || p == 4) ? 16'h0ffe : (p >= 3) ? 16'h1002 : 16'h1000;
			setw(5, 16'h1000);
			run(frm(4'h4, 1'b0, `LAE_M_DIRECT, 4'h6, {p[2:0], 4'h5}));
			getw(6, (p == 0) ? 16'h1000 : pw(ea));
			getw(5, pa);
		end
		// Byte source post-increment steps by one and keeps the high byte
		setw(5, 16'h1001);
		run(frm(4'h4, 1'b1, `LAE_M_DIRECT, 4'h6, {3'h3, 4'h5}));
		getw(6, 16'h2f2d);
		getw(5, 16'h1002);
		// Reserved target mode is refused at decode, never busy when polled
		run(frm(4'h0, 1'b0, 3'h6, 4'h2, 7'h00), 1'b0);
		rd(ASTAT, 32'h2);
		wr(ASTAT, 32'h2);
		rd(ASTAT, 32'h0);
	endtask : t_reg

	initial
	begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_literal();
		t_short();
		t_reg();
		wrap_up();
	end
endmodule : lae_unit_bench
